// ===== design/afc_config_regs.sv
// afc_config_regs: shadowed configuration bank, clock divider with phase
// delay and sync, and output test pattern source.
// assumes a single-cycle register port synchronous to ref_clk and a sync
// pulse input already aligned to ref_clk, which also serves as input clock.
`timescale 1ns/1ps

// Overview of operation
// RULE_01: internal power field 00 and 11 run normally, 01 powers down, 10 is standby.
// RULE_02: pin function bit chooses whether the power pin forces power-down (0) or standby (1).
// RULE_03: clock divides by ratio field plus one and any nonzero ratio forces the stabilizer on.
// RULE_04: a nonzero test field replaces output data with the selected pattern, 000 is off.
// RULE_05: output mode sets type, drive, disable, inversion and data format.
// RULE_06: phase field delays the divider input by that many clocks, another bit inverts the strobe.
// RULE_07: strobe delay is 2500 ps times field over 31, and self-test reset clears once used.
// RULE_08: shadowed writes act only when 0x01 lands in transfer, which then clears itself.
// RULE_09: sync needs master enable, and with divider enable every pulse realigns the divider.
// RULE_10: with next-sync-only the first pulse aligns the divider and clears divider enable.
module afc_config_regs #(
  parameter int DATA_W = 14
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic power_pin,
  input wire logic sync_in,
  input wire logic [DATA_W-1:0] adc_data,
  input wire logic [15:0] self_test_sig,
  output logic [7:0] reg_rdata,
  output logic [1:0] power_state,
  output logic dcs_active,
  output logic div_clk_en,
  output logic [DATA_W-1:0] out_data,
  output logic out_lvds,
  output logic out_reduced_drive,
  output logic out_disable,
  output logic strobe_invert,
  output logic [afc_pkg::DLY_PS_W-1:0] strobe_delay_ps,
  output logic [1:0] reference_range,
  output logic dither_en,
  output logic self_test_run,
  output logic self_test_reset
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [9:0][7:0] shadow;   // host-written copies
    logic [9:0][7:0] active;   // copies in force
    logic [7:0] sync_ctl;
    logic [2:0] div_cnt;
    logic [2:0] phase_cnt;
    logic [22:0] pn23;
    logic [8:0] pn9;
    logic toggle;
    logic [7:0] rdata;
    logic [1:0] power;
    logic dcs;
    logic div_en;
    logic [DATA_W-1:0] dout;
    logic [afc_pkg::DLY_PS_W-1:0] dly_ps;
  } afc_state_type;

  afc_state_type st;
  afc_state_type next_st;

  // index of each shadowed register in the arrays
  localparam int I_PWR = 0, I_GCK = 1, I_DIV = 2, I_TST = 3, I_BST = 4;
  localparam int I_OUT = 5, I_PHS = 6, I_DLY = 7, I_REF = 8, I_DTH = 9;

  // maps a shadowed address to its slot, 4'hf when not shadowed
  function automatic logic [3:0] slot_of(input logic [8:0] a);
    case (a)
      afc_pkg::ADDR_POWER_MODES: slot_of = 4'h0;
      afc_pkg::ADDR_GLOBAL_CLOCK: slot_of = 4'h1;
      afc_pkg::ADDR_CLOCK_DIVIDE: slot_of = 4'h2;
      afc_pkg::ADDR_TEST_PATTERN: slot_of = 4'h3;
      afc_pkg::ADDR_SELF_TEST: slot_of = 4'h4;
      afc_pkg::ADDR_OUTPUT_MODE: slot_of = 4'h5;
      afc_pkg::ADDR_CLOCK_PHASE: slot_of = 4'h6;
      afc_pkg::ADDR_STROBE_DELAY: slot_of = 4'h7;
      afc_pkg::ADDR_REFERENCE: slot_of = 4'h8;
      afc_pkg::ADDR_DITHER: slot_of = 4'h9;
      default: slot_of = 4'hf;
    endcase
  endfunction

  // writable bits of each slot; open bits stay zero
  function automatic logic [7:0] mask_of(input logic [3:0] s);
    case (s)
      4'h0: mask_of = afc_pkg::MASK_POWER_MODES;
      4'h1: mask_of = afc_pkg::MASK_GLOBAL_CLOCK;
      4'h2: mask_of = afc_pkg::MASK_3BIT;
      4'h3: mask_of = afc_pkg::MASK_TEST_PATTERN;
      4'h4: mask_of = afc_pkg::MASK_SELF_TEST;
      4'h5: mask_of = afc_pkg::MASK_OUTPUT_MODE;
      4'h6: mask_of = afc_pkg::MASK_CLOCK_PHASE;
      4'h7: mask_of = afc_pkg::MASK_STROBE_DELAY;
      4'h8: mask_of = afc_pkg::MASK_REFERENCE;
      4'h9: mask_of = afc_pkg::MASK_DITHER;
      default: mask_of = 8'h00;
    endcase
  endfunction

  localparam logic [9:0][7:0] RST_SET = {afc_pkg::RST_DITHER,
    afc_pkg::RST_REFERENCE, afc_pkg::RST_STROBE_DELAY,
    afc_pkg::RST_CLOCK_PHASE, afc_pkg::RST_OUTPUT_MODE,
    afc_pkg::RST_SELF_TEST, afc_pkg::RST_TEST_PATTERN,
    afc_pkg::RST_CLOCK_DIVIDE, afc_pkg::RST_GLOBAL_CLOCK,
    afc_pkg::RST_POWER_MODES};

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  logic [3:0] wslot;
  logic xfer;
  logic [7:0] pwr_r, tst_r, out_r, phs_r;
  logic [2:0] ratio;
  logic sync_go, div_wrap;
  logic [DATA_W-1:0] pat;
  logic [DATA_W-1:0] mid;

  always_comb begin
    next_st = st;
    wslot = slot_of(reg_addr);
    xfer = reg_wr && reg_addr == afc_pkg::ADDR_TRANSFER
      && reg_wdata == afc_pkg::TRANSFER_CMD;
    pwr_r = st.active[I_PWR];
    tst_r = st.active[I_TST];
    out_r = st.active[I_OUT];
    phs_r = st.active[I_PHS];
    ratio = st.active[I_DIV][2:0];
    mid = '0;
    mid[DATA_W-1] = 1'b1;
    // writes land only in the shadow copy until a transfer
    if (reg_wr && wslot != 4'hf) begin // see RULE_08
      next_st.shadow[wslot] = reg_wdata & mask_of(wslot);
    end
    if (reg_wr && reg_addr == afc_pkg::ADDR_SYNC) begin
      next_st.sync_ctl = reg_wdata & 8'h07;
    end
    // transfer copies every shadow at once; no transfer bit is kept, so it
    // reads back as zero, i.e. cleared by itself
    if (xfer) begin // see RULE_08
      next_st.active = next_st.shadow;
    end
    // self-test reset is a one-shot: cleared in both copies once acted on
    if (st.active[I_BST][afc_pkg::SELF_TEST_RST_BIT] && !xfer) begin
      next_st.active[I_BST][afc_pkg::SELF_TEST_RST_BIT] = 1'b0; // see RULE_07
      if (!(reg_wr && wslot == 4'(I_BST))) begin
        next_st.shadow[I_BST][afc_pkg::SELF_TEST_RST_BIT] = 1'b0;
      end
    end
    // power decode, the pin overriding the register setting
    if (power_pin) begin // see RULE_02
      next_st.power = pwr_r[afc_pkg::PIN_FUNC_BIT] ? afc_pkg::AFC_PWR_STANDBY
        : afc_pkg::AFC_PWR_DOWN;
    end else begin
      case (pwr_r[1:0]) // see RULE_01
        2'b01: next_st.power = afc_pkg::AFC_PWR_DOWN;
        2'b10: next_st.power = afc_pkg::AFC_PWR_STANDBY;
        default: next_st.power = afc_pkg::AFC_PWR_NORMAL;
      endcase
    end
    next_st.dcs = st.active[I_GCK][afc_pkg::DCS_BIT] || ratio != 3'h0; // see RULE_03
    // sync: master enable gates everything
    sync_go = sync_in && st.sync_ctl[afc_pkg::MASTER_SYNC_BIT]
      && st.sync_ctl[afc_pkg::DIV_SYNC_BIT]; // see RULE_09
    if (sync_go && st.sync_ctl[afc_pkg::NEXT_SYNC_BIT]
        && !(reg_wr && reg_addr == afc_pkg::ADDR_SYNC)) begin
      next_st.sync_ctl[afc_pkg::DIV_SYNC_BIT] = 1'b0; // see RULE_10
    end
    // divider: phase delay counts input clocks before counting starts
    div_wrap = 1'b0;
    if (sync_go) begin // see RULE_09
      next_st.div_cnt = 3'h0;
      next_st.phase_cnt = phs_r[2:0]; // see RULE_06
    end else if (st.phase_cnt != 3'h0) begin
      next_st.phase_cnt = st.phase_cnt - 3'h1; // see RULE_06
    end else if (st.div_cnt >= ratio) begin
      next_st.div_cnt = 3'h0;
      div_wrap = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 3'h1; // see RULE_03
    end
    if (xfer) begin
      next_st.phase_cnt = next_st.shadow[I_PHS][2:0]; // see RULE_06
    end
    next_st.div_en = div_wrap;
    // pattern generators advance on each sample, reset bits reseed them
    next_st.pn23 = {st.pn23[21:0], st.pn23[22] ^ st.pn23[17]};
    next_st.pn9 = {st.pn9[7:0], st.pn9[8] ^ st.pn9[4]};
    next_st.toggle = !st.toggle;
    if (tst_r[afc_pkg::TEST_RESET_LONG_BIT]) next_st.pn23 = '1;
    if (tst_r[afc_pkg::TEST_RESET_SHORT_BIT]) next_st.pn9 = '1;
    case (tst_r[2:0]) // see RULE_04
      3'h1: pat = mid;
      3'h2: pat = {1'b1, {(DATA_W-1){1'b1}}};
      3'h3: pat = '0;
      3'h4: pat = st.toggle ? {(DATA_W/2){2'b10}} : {(DATA_W/2){2'b01}};
      3'h5: pat = DATA_W'(st.pn23);
      3'h6: pat = DATA_W'(st.pn9);
      3'h7: pat = st.toggle ? '1 : '0;
      default: pat = adc_data;
    endcase
    // format: offset binary, twos complement (flip msb) or gray
    case (out_r[1:0]) // see RULE_05
      2'b01: pat = pat ^ mid;
      2'b10: pat = pat ^ (pat >> 1);
      default: pat = pat;
    endcase
    if (out_r[afc_pkg::OUT_INVERT_BIT]) pat = ~pat; // see RULE_05
    next_st.dout = pat;
    next_st.dly_ps = afc_pkg::DLY_PS_W'((afc_pkg::STROBE_FULL_PS
      * int'(st.active[I_DLY][4:0])) / afc_pkg::STROBE_STEPS); // see RULE_07
    // read mux answers the next cycle; unmapped addresses read zero
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      if (wslot != 4'hf) next_st.rdata = st.shadow[wslot];
      else if (reg_addr == afc_pkg::ADDR_SYNC) next_st.rdata = st.sync_ctl;
      else if (reg_addr == afc_pkg::ADDR_SIG_LOW)
        next_st.rdata = self_test_sig[7:0];
      else if (reg_addr == afc_pkg::ADDR_SIG_HIGH)
        next_st.rdata = self_test_sig[15:8];
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.shadow <= RST_SET;
      st.active <= RST_SET;
      st.dcs <= 1'b1;
      st.pn23 <= '1;
      st.pn9 <= '1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign reg_rdata = st.rdata;
  assign power_state = st.power;
  assign dcs_active = st.dcs;
  assign div_clk_en = st.div_en;
  assign out_data = st.dout;
  assign out_lvds = st.active[I_OUT][afc_pkg::OUT_TYPE_BIT]; // see RULE_05
  assign out_reduced_drive = st.active[I_OUT][afc_pkg::DRIVE_BIT];
  assign out_disable = st.active[I_OUT][afc_pkg::OUT_DISABLE_BIT];
  assign strobe_invert = st.active[I_PHS][afc_pkg::STROBE_INV_BIT]; // see RULE_06
  assign strobe_delay_ps = st.dly_ps;
  assign reference_range = st.active[I_REF][7:6];
  assign dither_en = st.active[I_DTH][afc_pkg::DITHER_BIT];
  assign self_test_run = st.active[I_BST][afc_pkg::SELF_TEST_EN_BIT];
  assign self_test_reset = st.active[I_BST][afc_pkg::SELF_TEST_RST_BIT];

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  shadow_holds_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !xfer |=> st.active == $past(st.active) || $past(st.active[I_BST][2]))
    else $error("active copy changed without transfer"); // see RULE_08
  xfer_copies_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    xfer |=> st.active[I_DIV] == $past(next_st.shadow[I_DIV]))
    else $error("transfer did not copy shadow"); // see RULE_08
  pin_down_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    power_pin && !pwr_r[5] |=> power_state == afc_pkg::AFC_PWR_DOWN)
    else $error("pin did not force power-down"); // see RULE_02
  pwr_decode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !power_pin && pwr_r[1:0] == 2'b10 |=> power_state == 2'(2))
    else $error("standby not decoded"); // see RULE_01
  dcs_force_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ratio != 3'h0 |=> dcs_active)
    else $error("stabilizer not forced"); // see RULE_03
  div_period_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ratio == 3'h1 && !xfer && !sync_go && st.phase_cnt == 3'h0
      && div_clk_en ##1 (!xfer && !sync_go) |=> div_clk_en)
    else $error("divide by two period wrong"); // see RULE_03
  phase_wait_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st.phase_cnt != 3'h0 && !sync_go && !xfer |=> !div_clk_en)
    else $error("divider ran during phase delay"); // see RULE_06
  sync_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sync_in && !st.sync_ctl[0] && !xfer && st.phase_cnt == 3'h0
      |=> st.div_cnt != 3'h0 || $past(st.div_cnt) >= $past(ratio))
    else $error("sync acted without master enable"); // see RULE_09
  one_shot_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sync_go && st.sync_ctl[2] && !(reg_wr && reg_addr == 9'h100)
      |=> !st.sync_ctl[1])
    else $error("divider sync enable not cleared"); // see RULE_10
  bist_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    self_test_reset && !xfer |=> !self_test_reset)
    else $error("self-test reset did not clear"); // see RULE_07

endmodule

// ===== design/afc_pkg.sv
// afc_pkg: register map, field positions, reset values and timing counts
// for the converter feature configuration bank.
// assumes a byte-wide register port decoded on a 9-bit address.
package afc_pkg;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [8:0] ADDR_POWER_MODES = 9'h008;
  localparam logic [8:0] ADDR_GLOBAL_CLOCK = 9'h009;
  localparam logic [8:0] ADDR_CLOCK_DIVIDE = 9'h00b;
  localparam logic [8:0] ADDR_TEST_PATTERN = 9'h00d;
  localparam logic [8:0] ADDR_SELF_TEST = 9'h00e;
  localparam logic [8:0] ADDR_OUTPUT_MODE = 9'h014;
  localparam logic [8:0] ADDR_CLOCK_PHASE = 9'h016;
  localparam logic [8:0] ADDR_STROBE_DELAY = 9'h017;
  localparam logic [8:0] ADDR_REFERENCE = 9'h018;
  localparam logic [8:0] ADDR_SIG_LOW = 9'h024;
  localparam logic [8:0] ADDR_SIG_HIGH = 9'h025;
  localparam logic [8:0] ADDR_DITHER = 9'h030;
  localparam logic [8:0] ADDR_TRANSFER = 9'h0ff;
  localparam logic [8:0] ADDR_SYNC = 9'h100;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_POWER_MODES = 8'h80;
  localparam logic [7:0] RST_GLOBAL_CLOCK = 8'h01;
  localparam logic [7:0] RST_CLOCK_DIVIDE = 8'h00;
  localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
  localparam logic [7:0] RST_SELF_TEST = 8'h04;
  localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
  localparam logic [7:0] RST_CLOCK_PHASE = 8'h00;
  localparam logic [7:0] RST_STROBE_DELAY = 8'h00;
  localparam logic [7:0] RST_REFERENCE = 8'hc0;
  localparam logic [7:0] RST_DITHER = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [7:0] TRANSFER_CMD = 8'h01;

  // ------------------------------------------------------------------
  // field positions and writable masks
  // ------------------------------------------------------------------
  localparam int PIN_FUNC_BIT = 5;
  localparam int DCS_BIT = 0;
  localparam int TEST_RESET_LONG_BIT = 5;
  localparam int TEST_RESET_SHORT_BIT = 4;
  localparam int SELF_TEST_EN_BIT = 0;
  localparam int SELF_TEST_RST_BIT = 2;
  localparam int DRIVE_BIT = 7;
  localparam int OUT_TYPE_BIT = 6;
  localparam int OUT_DISABLE_BIT = 4;
  localparam int OUT_INVERT_BIT = 2;
  localparam int STROBE_INV_BIT = 7;
  localparam int DITHER_BIT = 4;
  localparam int MASTER_SYNC_BIT = 0;
  localparam int DIV_SYNC_BIT = 1;
  localparam int NEXT_SYNC_BIT = 2;
  localparam logic [7:0] MASK_POWER_MODES = 8'ha3;
  localparam logic [7:0] MASK_GLOBAL_CLOCK = 8'h01;
  localparam logic [7:0] MASK_3BIT = 8'h07;
  localparam logic [7:0] MASK_TEST_PATTERN = 8'h37;
  localparam logic [7:0] MASK_SELF_TEST = 8'h05;
  localparam logic [7:0] MASK_OUTPUT_MODE = 8'hd7;
  localparam logic [7:0] MASK_CLOCK_PHASE = 8'h87;
  localparam logic [7:0] MASK_STROBE_DELAY = 8'h1f;
  localparam logic [7:0] MASK_REFERENCE = 8'hc0;
  localparam logic [7:0] MASK_DITHER = 8'h10;

  // ------------------------------------------------------------------
  // timing: strobe delay full scale and its step divisor
  // ------------------------------------------------------------------
  localparam int STROBE_FULL_PS = 2500;
  localparam int STROBE_STEPS = 31;
  localparam int DLY_PS_W = 12;

  // power modes as decoded for the analog side
  typedef enum logic [1:0] {
    AFC_PWR_NORMAL, AFC_PWR_DOWN, AFC_PWR_STANDBY
  } afc_power_type;

endpackage

// ===== test/afc_host_model.sv
// afc_host_model: register port host that programs the feature bank.
// assumes it shares ref_clk with the bank and runs one task at a time.
`timescale 1ns/1ps
module afc_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [8:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // --------------------------------------------------------------
  // bus cycles
  // --------------------------------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h1ff;
    reg_wdata = 8'hff;
  end

  // one write; address and data are scrambled once the edge has taken them
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // one read; data is registered, so it is taken just after the edge
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // shadowed values only act once the transfer command lands
  task automatic commit();
    wr(afc_pkg::ADDR_TRANSFER, afc_pkg::TRANSFER_CMD);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
endmodule

// ===== test/testbench.sv
// testbench: register sequences against the feature configuration bank.
// assumes the host model owns the register port and the bench owns pins.
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic power_pin = 1'b0;
  logic sync_in = 1'b0;
  logic [13:0] adc_data = 14'h0123;
  logic [15:0] self_test_sig = 16'h5aa5;
  logic reg_wr, reg_rd, out_lvds, out_reduced_drive, out_disable;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] power_state, reference_range;
  logic dcs_active, div_clk_en, strobe_invert, dither_en;
  logic self_test_run, self_test_reset;
  logic [13:0] out_data;
  logic [afc_pkg::DLY_PS_W-1:0] strobe_delay_ps;
  int err_total = 0;
  int n_compared = 0;
  int g1, g2;

  always #12.5 ref_clk = ~ref_clk;

  afc_host_model u_afc_host_model (.ref_clk(ref_clk),
    .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  afc_config_regs #(.DATA_W(14)) u_afc_config_regs (.ref_clk(ref_clk),
    .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .power_pin(power_pin), .sync_in(sync_in),
    .adc_data(adc_data), .self_test_sig(self_test_sig),
    .reg_rdata(reg_rdata), .power_state(power_state),
    .dcs_active(dcs_active), .div_clk_en(div_clk_en), .out_data(out_data),
    .out_lvds(out_lvds), .out_reduced_drive(out_reduced_drive),
    .out_disable(out_disable), .strobe_invert(strobe_invert),
    .strobe_delay_ps(strobe_delay_ps), .reference_range(reference_range),
    .dither_en(dither_en), .self_test_run(self_test_run),
    .self_test_reset(self_test_reset));

  // --------------------------------------------------------------
  // compare, wait and closing tasks
  // --------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_reg(logic [8:0] a, logic [7:0] e);
    logic [7:0] d;
    u_afc_host_model.rd(a, d);
    n_compared++;
    if (d !== e) begin
      err_total++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, e, d);
    end
  endtask

  task automatic set(logic [8:0] a, logic [7:0] d);
    u_afc_host_model.wr(a, d);
    u_afc_host_model.commit();
  endtask

  // cycles from one divider pulse to the next, or from a sync pulse on
  // without a sync the first pulse only starts the count, the next ends it
  task automatic gap(input bit after_sync, output int n);
    bit seen;
    bit done;
    n = 0;
    seen = after_sync;
    done = 1'b0;
    for (int i = 0; i < 64 && !done; i++) begin
      @(posedge ref_clk);
      #1;
      if (seen) n++;
      if (div_clk_en === 1'b1 && seen && n > 0) done = 1'b1;
      else if (div_clk_en === 1'b1) seen = 1'b1;
    end
    if (!done) begin
      err_total++;
      $display("CHECK FAILED divider pulse expected within 64 seen none");
      test_done();
    end
  endtask

  task automatic sync_pulse();
    @(posedge ref_clk);
    sync_in <= 1'b1;
    @(posedge ref_clk);
    sync_in <= 1'b0;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    static logic [8:0] ra [13] = '{9'h008, 9'h009, 9'h00b, 9'h00d, 9'h00e,
      9'h014, 9'h016, 9'h017, 9'h018, 9'h030, 9'h100, 9'h0ff, 9'h013};
    static logic [7:0] rv [13] = '{8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00};
    static logic [1:0] pw [4] = '{2'd0, 2'd1, 2'd2, 2'd0};
    static logic [13:0] pat [4] = '{14'h0123, 14'h2000, 14'h3fff, 14'h0000};
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    // defaults; self-test reset has already cleared itself
    chk("dcs_active", 16'h1, {15'h0, dcs_active});
    chk("self_test_reset", 16'h0, {15'h0, self_test_reset});
    chk("reference_range", 16'h3, {14'h0, reference_range});
    for (int i = 0; i < 13; i++) chk_reg(ra[i], rv[i]);
    chk_reg(afc_pkg::ADDR_SIG_LOW, 8'ha5);
    chk_reg(afc_pkg::ADDR_SIG_HIGH, 8'h5a);
    u_afc_host_model.wr(9'h013, 8'hff);
    chk_reg(9'h013, 8'h00);
    // every power code; nothing moves before the transfer
    for (int i = 1; i < 4; i++) begin
      u_afc_host_model.wr(afc_pkg::ADDR_POWER_MODES, 8'h80 | 8'(i));
      repeat (3) @(posedge ref_clk);
      chk("power held", {14'h0, pw[i-1]}, {14'h0, power_state});
      u_afc_host_model.commit();
      chk("power_state", {14'h0, pw[i]}, {14'h0, power_state});
    end
    power_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("pin down", 16'h1, {14'h0, power_state});
    set(afc_pkg::ADDR_POWER_MODES, 8'ha0);
    chk("pin standby", 16'h2, {14'h0, power_state});
    power_pin <= 1'b0;
    // stabilizer and divide ratios
    u_afc_host_model.wr(afc_pkg::ADDR_GLOBAL_CLOCK, 8'h00);
    set(afc_pkg::ADDR_CLOCK_DIVIDE, 8'h00);
    chk("dcs off", 16'h0, {15'h0, dcs_active});
    foreach (pw[i]) begin
      set(afc_pkg::ADDR_CLOCK_DIVIDE, 8'(2 * i + 1));
      chk("dcs forced", 16'h1, {15'h0, dcs_active});
      gap(1'b0, g1);
      chk("div period", 16'(2 * i + 2), 16'(g1));
    end
    // output mode, masking and every test pattern code
    set(afc_pkg::ADDR_OUTPUT_MODE, 8'hff);
    chk_reg(afc_pkg::ADDR_OUTPUT_MODE, afc_pkg::MASK_OUTPUT_MODE);
    chk("out bits", 16'h7, {13'h0, out_lvds, out_reduced_drive,
      out_disable});
    set(afc_pkg::ADDR_OUTPUT_MODE, 8'h00);
    for (int i = 0; i < 8; i++) begin
      set(afc_pkg::ADDR_TEST_PATTERN, 8'(i));
      if (i < 4) chk("pattern", {2'h0, pat[i]}, {2'h0, out_data});
      else chk("pattern used", 16'h0,
        16'(out_data === adc_data));
      if (i == 4) chk("checkerboard", 16'h1,
        16'(out_data === 14'h2aaa || out_data === 14'h1555));
    end
    set(afc_pkg::ADDR_TEST_PATTERN, 8'h01);
    set(afc_pkg::ADDR_OUTPUT_MODE, 8'h01);
    chk("twos", 16'h0000, {2'h0, out_data});
    set(afc_pkg::ADDR_OUTPUT_MODE, 8'h02);
    chk("gray", 16'h3000, {2'h0, out_data});
    set(afc_pkg::ADDR_OUTPUT_MODE, 8'h04);
    chk("invert", 16'h1fff, {2'h0, out_data});
    // strobe invert, strobe delay steps, reference and dither
    set(afc_pkg::ADDR_CLOCK_PHASE, 8'h80);
    chk("strobe_invert", 16'h1, {15'h0, strobe_invert});
    set(afc_pkg::ADDR_STROBE_DELAY, 8'h1f);
    chk("delay max", 16'd2500, 16'(strobe_delay_ps));
    set(afc_pkg::ADDR_STROBE_DELAY, 8'h1e);
    chk("delay 30", 16'd2419, 16'(strobe_delay_ps));
    set(afc_pkg::ADDR_REFERENCE, 8'h40);
    chk("reference_range", 16'h1, {14'h0, reference_range});
    set(afc_pkg::ADDR_DITHER, 8'h10);
    chk("dither_en", 16'h1, {15'h0, dither_en});
    // self-test enable stays, its reset bit acts once and drops
    set(afc_pkg::ADDR_SELF_TEST, 8'h05);
    chk("self_test_run", 16'h1, {15'h0, self_test_run});
    chk("bist reset once", 16'h0, {15'h0, self_test_reset});
    chk_reg(afc_pkg::ADDR_SELF_TEST, 8'h01);
    // sync: gated by master, continuous realigns, next-only clears
    set(afc_pkg::ADDR_CLOCK_DIVIDE, 8'h03);
    u_afc_host_model.wr(afc_pkg::ADDR_SYNC, 8'h06);
    sync_pulse();
    chk_reg(afc_pkg::ADDR_SYNC, 8'h06);
    u_afc_host_model.wr(afc_pkg::ADDR_SYNC, 8'h03);
    sync_pulse();
    gap(1'b1, g1);
    @(posedge ref_clk);
    sync_pulse();
    gap(1'b1, g2);
    chk("sync first", 16'd4, 16'(g1));
    chk("sync realign", 16'd4, 16'(g2));
    chk_reg(afc_pkg::ADDR_SYNC, 8'h03);
    // phase delay of three clocks ahead of a divide-by-four period
    set(afc_pkg::ADDR_CLOCK_PHASE, 8'h83);
    sync_pulse();
    gap(1'b1, g1);
    chk("phase delay", 16'd7, 16'(g1));
    u_afc_host_model.wr(afc_pkg::ADDR_SYNC, 8'h07);
    sync_pulse();
    repeat (2) @(posedge ref_clk);
    chk_reg(afc_pkg::ADDR_SYNC, 8'h05);
    test_done();
  end
endmodule
